// >>> design/wcf_params.svh
// named constants of the write crc frame mapper
// assumes inclusion by the package and the design modules alike
`ifndef WCF_PARAMS_SVH
`define WCF_PARAMS_SVH

// frame geometry
`define WCF_BEATS        10
`define WCF_LANES        18
`define WCF_PIN_W        19
`define WCF_BYTE_LANES   9
`define WCF_DM_LANE      8
`define WCF_X4_LANES     4
`define WCF_LANE_BITS    8
`define WCF_BL8_BEATS    8
`define WCF_BC4_BEATS    4
`define WCF_BC4_HI_OFS   4
`define WCF_CRC_BEAT     8
`define WCF_CRC_HI_BEAT  9
`define WCF_LAST_CRC     4'h9
`define WCF_LAST_NOCRC   4'h7
`define WCF_TREES        2
`define WCF_DATA_W       144

// checksum
`define WCF_TREE_W       72
`define WCF_CRC_W        8
`define WCF_CRC_POLY     8'h07
`define WCF_CRC_INIT     8'h00
`define WCF_X4_NIB       4

// pin packing
`define WCF_PIN_BEAT     18

// buffering
`define WCF_FIFO_DEPTH   8

`endif

// >>> design/wcf_pkg.sv
// types shared by the write crc frame mapper and its testbench
// assumes the constants header sits beside this file
`include "wcf_params.svh"

package wcf_pkg;

  typedef enum logic [1:0]
  {
    WCF_X4,
    WCF_X8,
    WCF_X16
  } wcf_width_t;

  // mode settings held stable by the mode register logic
  typedef struct packed
  {
    wcf_width_t width;
    logic       bc4;
    logic       dm_en;
    logic       dbi_en;
    logic       crc_en;
  } wcf_cfg_t;

  // write command as decoded on the command bus
  typedef struct packed
  {
    logic [2:0] col_low;
    logic       otf;
  } wcf_cmd_t;

  // one frame as handed to the core
  typedef struct packed
  {
    logic [`WCF_DATA_W-1:0] data;
    logic                   bc4;
    logic                   a2;
    logic                   crc_err;
    logic                   pad_err;
  } wcf_word_t;

endpackage

// >>> design/wcf_fifo.sv
// small first-in first-out buffer with a registered read port
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
`include "wcf_params.svh"

module wcf_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = `WCF_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0]   count_q;
  logic          push;
  logic          pop;

  assign in_ready = (count_q < (AW+1)'(DEPTH));
  assign push     = in_valid && in_ready;
  // the output register refills whenever it is empty or being taken
  assign pop      = (count_q != '0) && (!out_valid || out_ready);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else if (pop)
    begin
      out_valid <= 1'b1;
      out_data  <= mem_q[rd_ptr_q];
    end
    else if (out_ready)
    begin
      out_valid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> design/wcf_mapper.sv
// receive side of the write data frame with checksum for a x4/x8/x16 dram
// assumes data pins sampled once per transfer by beat_pin, mode settings
// stable between frames, and a command pulse ahead of each frame
`timescale 1ns/1ps
`default_nettype none
`include "wcf_params.svh"

module wcf_mapper #(
  parameter int unsigned FIFO_DEPTH = `WCF_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // mode settings
  input  wire wcf_pkg::wcf_cfg_t cfg,
  // write command
  input  wire logic             cmd_valid,
  input  wire wcf_pkg::wcf_cmd_t cmd,
  // data pins
  input  wire logic             beat_pin,
  input  wire logic [15:0]      dq_pin,
  input  wire logic [1:0]       dm_pin,
  // alert pin, open drain
  output logic                  alert_out_q,
  output logic                  alert_oe_n_q,
  // status toward the controller side
  output logic                  frame_ready_q,
  output logic                  cmd_err_q,
  output logic                  overrun_q,
  // core write port
  output logic                  core_valid,
  input  wire logic             core_ready,
  output wcf_pkg::wcf_word_t    core_word
);

  import wcf_pkg::*;

  localparam int unsigned WW = $bits(wcf_word_t);

  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_RECV,
    ST_CHECK,
    ST_PUSH
  } wcf_state_t;

  function automatic logic [`WCF_CRC_W-1:0] wcf_crc8(
    input logic [`WCF_TREE_W-1:0] d
  );
    logic [`WCF_CRC_W-1:0] c;
    logic                  fb;
    c  = `WCF_CRC_INIT;
    fb = 1'b0;
    // first serial bit is the top of the word
    for (int i = `WCF_TREE_W-1; i >= 0; i--)
    begin
      fb = c[`WCF_CRC_W-1] ^ d[i];
      c  = {c[`WCF_CRC_W-2:0], 1'b0} ^ ({`WCF_CRC_W{fb}} & `WCF_CRC_POLY);
    end
    return c;
  endfunction

  wcf_state_t                           state_q;
  logic [`WCF_PIN_W-1:0]                pin_s1_q;
  logic [`WCF_PIN_W-1:0]                pin_s2_q;
  logic                                 s_beat;
  logic [`WCF_LANES-1:0]                s_lanes;
  logic [`WCF_BEATS-1:0][`WCF_LANES-1:0] beat_q;
  logic [3:0]                           beat_cnt_q;
  logic                                 last_beat;
  wcf_cfg_t                             cfg_q;
  logic                                 a2_q;
  logic                                 cmd_bad;
  logic                                 x4;
  logic                                 x16;
  logic                                 dmdbi;
  logic [`WCF_TREES-1:0][`WCF_TREE_W-1:0] tree_w;
  logic [`WCF_TREES-1:0][`WCF_CRC_W-1:0]  calc_crc;
  logic [`WCF_TREES-1:0][`WCF_CRC_W-1:0]  rx_crc;
  logic [`WCF_TREES-1:0]                pad_bad;
  logic                                 crc_bad;
  logic                                 any_pad_bad;
  logic                                 drop;
  logic                                 crc_err_q;
  logic                                 pad_err_q;
  logic [`WCF_DATA_W-1:0]               frame_data;
  wcf_word_t                            push_word;
  logic                                 fifo_in_ready;

  ////////////////////////////////////////////////////////////////////////////
  // pins cross into sys_clk through two flops; only stage two is read
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end
    else
    begin
      pin_s1_q <= {beat_pin, dm_pin[1], dq_pin[15:8], dm_pin[0], dq_pin[7:0]};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign s_beat  = pin_s2_q[`WCF_PIN_BEAT];
  assign s_lanes = pin_s2_q[`WCF_LANES-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // command checks: fixed order for bl8 and no otf chop under fixed bc4, both with crc
  assign cmd_bad = (cfg.crc_en && !cfg.bc4 && (cmd.col_low != 3'h0))
                || (cfg.crc_en && cfg.bc4 && cmd.otf);

  assign x4        = (cfg_q.width == WCF_X4);
  assign x16       = (cfg_q.width == WCF_X16);
  assign dmdbi     = cfg_q.dm_en || cfg_q.dbi_en;
  // without crc the frame is eight transfers long
  assign last_beat = (beat_cnt_q == (cfg_q.crc_en ? `WCF_LAST_CRC
                                                  : `WCF_LAST_NOCRC));

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (cmd_valid && !cmd_bad)
          begin
            state_q <= ST_RECV;
          end
        end
        ST_RECV:
        begin
          if (s_beat && last_beat)
          begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK:
        begin
          state_q <= drop ? ST_IDLE : ST_PUSH;
        end
        default:
        begin
          if (fifo_in_ready)
          begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // frame settings are frozen for the whole frame
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cfg_q <= '0;
      a2_q  <= 1'b0;
    end
    else if (state_q == ST_IDLE && cmd_valid && !cmd_bad)
    begin
      cfg_q <= cfg;
      a2_q  <= cfg.bc4 && cmd.col_low[2];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      beat_cnt_q <= '0;
      beat_q     <= '0;
    end
    else if (state_q == ST_IDLE)
    begin
      beat_cnt_q <= '0;
    end
    else if (state_q == ST_RECV && s_beat)
    begin
      beat_q[beat_cnt_q] <= s_lanes;
      beat_cnt_q         <= beat_cnt_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one checksum tree per byte group; the upper one only counts on x16
  for (genvar k = 0; k < `WCF_TREES; k++)
  begin : g_tree
    always_comb
    begin
      tree_w[k]  = '1;
      pad_bad[k] = 1'b0;
      for (int l = 0; l < `WCF_BYTE_LANES; l++)
      begin
        for (int b = 0; b < `WCF_BEATS; b++)
        begin
          int  j;
          int  pos;
          int  nb;
          logic lane_on;
          logic is_data;
          logic is_crc;
          j       = k * `WCF_BYTE_LANES + l;
          nb      = cfg_q.bc4 ? `WCF_BC4_BEATS : `WCF_BL8_BEATS;
          lane_on = x4 ? (k == 0 && l < `WCF_X4_LANES) : (k == 0 || x16);
          is_data = lane_on && (b < nb)
                 && ((l != `WCF_DM_LANE) || dmdbi);
          is_crc  = lane_on && (l != `WCF_DM_LANE) && cfg_q.crc_en
                 && ((b == `WCF_CRC_BEAT)
                  || (x4 && b == `WCF_CRC_HI_BEAT));
          // mask lane of an a2 high chop lands on tree inputs 68-71
          pos = (l == `WCF_DM_LANE && cfg_q.bc4 && a2_q)
              ? l * `WCF_LANE_BITS + `WCF_BC4_HI_OFS + b
              : l * `WCF_LANE_BITS + b;
          if (is_data)
          begin
            tree_w[k][pos] = beat_q[b][j];
          end
          // slots beyond data and checksum must arrive high
          if (lane_on && !is_data && !is_crc
              && (cfg_q.crc_en || b < `WCF_BL8_BEATS)
              && !beat_q[b][j])
          begin
            pad_bad[k] = 1'b1;
          end
        end
      end
      calc_crc[k] = wcf_crc8(tree_w[k]);
    end
  end

  // x4 splits its checksum over two transfers of four lanes
  assign rx_crc[0] = x4
    ? {beat_q[`WCF_CRC_HI_BEAT][`WCF_X4_NIB-1:0],
       beat_q[`WCF_CRC_BEAT][`WCF_X4_NIB-1:0]}
    : beat_q[`WCF_CRC_BEAT][`WCF_CRC_W-1:0];
  assign rx_crc[1] = beat_q[`WCF_CRC_BEAT]
                           [`WCF_BYTE_LANES+`WCF_CRC_W-1:`WCF_BYTE_LANES];

  assign crc_bad = cfg_q.crc_en
                && ((calc_crc[0] != rx_crc[0])
                 || (x16 && (calc_crc[1] != rx_crc[1])));
  assign any_pad_bad = |pad_bad;
  // with masking on, a write whose checksum fails never reaches the core
  assign drop    = crc_bad && cfg_q.dm_en;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      crc_err_q <= 1'b0;
      pad_err_q <= 1'b0;
    end
    else if (state_q == ST_CHECK)
    begin
      crc_err_q <= crc_bad;
      pad_err_q <= any_pad_bad;
    end
  end

  // one low cycle on the alert pin per failing frame; the pin only sinks
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      alert_out_q  <= 1'b0;
      alert_oe_n_q <= 1'b1;
    end
    else
    begin
      alert_out_q  <= 1'b0;
      alert_oe_n_q <= !(state_q == ST_CHECK && crc_bad);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      frame_ready_q <= 1'b0;
      cmd_err_q     <= 1'b0;
      overrun_q     <= 1'b0;
    end
    else
    begin
      frame_ready_q <= (state_q == ST_IDLE);
      cmd_err_q     <= (state_q == ST_IDLE) && cmd_valid && cmd_bad;
      // pins cannot be stalled, so traffic while busy is only reported
      overrun_q     <= ((state_q != ST_IDLE) && cmd_valid)
                    || ((state_q == ST_CHECK || state_q == ST_PUSH)
                        && s_beat);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core gets raw lane-major data; a2 says where a chopped nibble belongs
  always_comb
  begin
    frame_data = '0;
    for (int j = 0; j < `WCF_LANES; j++)
    begin
      for (int b = 0; b < `WCF_BL8_BEATS; b++)
      begin
        frame_data[j * `WCF_LANE_BITS + b] = beat_q[b][j];
      end
    end
  end

  assign push_word.data    = frame_data;
  assign push_word.bc4     = cfg_q.bc4;
  assign push_word.a2      = a2_q;
  assign push_word.crc_err = crc_err_q;
  assign push_word.pad_err = pad_err_q;

  wcf_fifo #(
    .W     (WW),
    .DEPTH (FIFO_DEPTH)
  ) wcf_fifo_inst (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (state_q == ST_PUSH),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word),
    .out_valid (core_valid),
    .out_ready (core_ready),
    .out_data  (core_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence wcf_alert_seq;
    !alert_oe_n_q ##1 alert_oe_n_q;
  endsequence

  order_check_a: assert property (
    (state_q == ST_IDLE && cmd_valid && cfg.crc_en && !cfg.bc4
     && cmd.col_low != 3'h0) |=> cmd_err_q && state_q == ST_IDLE)
    else $error("bl8 crc write with nonzero column bits was taken");

  otf_refuse_a: assert property (
    (state_q == ST_IDLE && cmd_valid && cfg.crc_en && cfg.bc4 && cmd.otf)
    |=> cmd_err_q && state_q == ST_IDLE)
    else $error("otf chop under fixed bc4 crc was taken");

  alert_pulse_a: assert property (
    (state_q == ST_CHECK && crc_bad) |=> wcf_alert_seq)
    else $error("checksum mismatch did not pulse alert for one cycle");

  alert_cause_a: assert property (
    !alert_oe_n_q |-> $past(state_q == ST_CHECK) && crc_err_q)
    else $error("alert driven without a failed frame");

  drop_bad_a: assert property (
    (state_q == ST_CHECK && crc_bad && cfg_q.dm_en)
    |=> state_q == ST_IDLE ##1 !(state_q == ST_PUSH))
    else $error("failed masked write was pushed to the core");

  x4_ones_a: assert property (
    (state_q == ST_CHECK && x4)
    |-> tree_w[0][`WCF_TREE_W-1:`WCF_X4_NIB*`WCF_LANE_BITS] == '1)
    else $error("x4 tree inputs above bit 31 not forced high");

  bc4_nibble_a: assert property (
    (state_q == ST_CHECK && cfg_q.bc4 && !x4)
    |-> tree_w[0][7:4] == 4'hf && tree_w[0][63:60] == 4'hf)
    else $error("bc4 upper nibble tree inputs not forced high");

  mask_off_a: assert property (
    (state_q == ST_CHECK && !dmdbi && !x4)
    |-> tree_w[0][`WCF_TREE_W-1:`WCF_DM_LANE*`WCF_LANE_BITS] == '1)
    else $error("mask lane fed the tree while mask and inversion off");

  push_hold_a: assert property (
    (state_q == ST_PUSH && !fifo_in_ready)
    |=> state_q == ST_PUSH && $stable(push_word))
    else $error("frame left the push stage before the buffer took it");

endmodule

`default_nettype wire

// >>> dv/wcf_ctrl_model.sv
// controller-side model: builds write frames and their checksum
// assumes the mapper's two-flop beat synchroniser and one clock
`timescale 1ns/1ps
`default_nettype none

module wcf_ctrl_model
(
  // clock
  input  wire logic              sys_clk,
  // command and data pins
  output var  logic              cmd_valid,
  output var  wcf_pkg::wcf_cmd_t cmd,
  output var  logic              beat_pin,
  output var  logic [15:0]       dq_pin,
  output var  logic [1:0]        dm_pin
);
  import wcf_pkg::*;
  typedef logic [17:0] wcf_frm_t [10];

  initial
  begin
    cmd_valid = 1'b0;
    cmd = '0;
    beat_pin = 1'b0;
    dq_pin = '0;
    dm_pin = '0;
  end

  ////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] crc8(input logic [71:0] t);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 71; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ t[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  // unused tree inputs stay one
  function automatic logic [71:0] tree(input wcf_frm_t fr, input int base,
                                       input wcf_cfg_t c, input logic a2);
    logic [71:0] t;
    t = '1;
    for (int l = 0; l < 9; l++)
      for (int b = 0; b < 8; b++)
        if (!((c.width == WCF_X4 && l > 3) || (c.bc4 && b > 3) ||
              (l == 8 && !(c.dm_en || c.dbi_en))))
          t[(c.bc4 && a2 && l == 8) ? 68 + b : 8 * l + b] =
            fr[b][base + l];
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////
  task automatic send(input wcf_cfg_t c, input logic [2:0] col,
                      input logic otf, input logic [143:0] d,
                      input logic [1:0] flt, output logic [143:0] raw);
    wcf_frm_t fr;
    logic [7:0] lo;
    logic a2;
    int lim;
    int sh;
    a2 = c.bc4 & col[2];
    sh = a2 ? 4 : 0;
    lim = (c.width == WCF_X4) ? 4 : (c.width == WCF_X8) ? 9 : 18;
    for (int b = 0; b < 10; b++)
      for (int l = 0; l < 18; l++)
        // mask lanes carry ones while mask and inversion are off
        fr[b][l] = (l < lim && b < 8 && !(c.bc4 && b > 3) &&
                    !(l % 9 == 8 && !(c.dm_en || c.dbi_en))) ?
                   d[8 * l + b + sh] : 1'b1;
    for (int b = 0; b < 8; b++)
      for (int l = 0; l < 18; l++)
        raw[8 * l + b] = fr[b][l];
    lo = crc8(tree(fr, 0, c, a2)) ^ {7'h00, flt[0]};
    if (c.width == WCF_X4)
    begin
      fr[8][3:0] = lo[3:0];
      fr[9][3:0] = lo[7:4];
    end
    else
      fr[8][7:0] = lo;
    if (c.width == WCF_X16)
      fr[8][16:9] = crc8(tree(fr, 9, c, a2));
    if (flt[1])
      fr[9][0] = 1'b0;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd <= {col, otf};
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    // data held around each strobe so either sampling point sees it
    for (int b = 0; b < (c.crc_en ? 10 : 8); b++)
    begin
      dq_pin <= {fr[b][16:9], fr[b][7:0]};
      dm_pin <= {fr[b][17], fr[b][8]};
      beat_pin <= 1'b1;
      @(posedge sys_clk);
      beat_pin <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
    dq_pin <= ~dq_pin;
    dm_pin <= ~dm_pin;
  endtask

  task automatic cmd_only;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd <= '0;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
  endtask

endmodule

`default_nettype wire

// >>> dv/wcf_mapper_tb.sv
// self-checking bench for the write frame mapper
// assumes the controller model drives the command and data pins
`timescale 1ns/1ps
`default_nettype none

module wcf_mapper_tb;
  import wcf_pkg::*;
  localparam int unsigned DEPTH = 2;
  logic              sys_clk;
  logic              rst;
  logic              cmd_valid;
  logic              beat_pin;
  logic [15:0]       dq_pin;
  logic [1:0]        dm_pin;
  logic              alert_out_q;
  logic              alert_oe_n_q;
  logic              frame_ready_q;
  logic              cmd_err_q;
  logic              overrun_q;
  logic              core_valid;
  logic              core_ready;
  wcf_cfg_t          cfg;
  wcf_cmd_t          cmd;
  wcf_word_t         core_word;
  wcf_word_t         got [$];
  wcf_word_t         exp_q [$];
  int                n_errors = 0;
  int                check_count = 0;
  int                cycles = 0;
  int                n_alert = 0;
  int                n_cerr = 0;
  int                n_ovr = 0;

  wcf_mapper #(.FIFO_DEPTH(DEPTH)) wcf_mapper_inst (
    .sys_clk(sys_clk), .rst(rst), .cfg(cfg), .cmd_valid(cmd_valid),
    .cmd(cmd), .beat_pin(beat_pin), .dq_pin(dq_pin), .dm_pin(dm_pin),
    .alert_out_q(alert_out_q), .alert_oe_n_q(alert_oe_n_q),
    .frame_ready_q(frame_ready_q), .cmd_err_q(cmd_err_q),
    .overrun_q(overrun_q), .core_valid(core_valid),
    .core_ready(core_ready), .core_word(core_word));

  wcf_ctrl_model wcf_ctrl_model_inst (
    .sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd(cmd),
    .beat_pin(beat_pin), .dq_pin(dq_pin), .dm_pin(dm_pin));

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk)
  begin
    cycles++;
    if (core_valid === 1'b1 && core_ready === 1'b1)
      got.push_back(core_word);
    n_alert += (alert_oe_n_q === 1'b0);
    n_cerr += (cmd_err_q === 1'b1);
    n_ovr += (overrun_q === 1'b1);
    if (!rst && alert_out_q !== 1'b0)
    begin
      n_errors++;
      $display("[ERR] %0t alert drive value not low", $time);
    end
    if (cycles > 8000)
    begin
      n_errors++;
      $display("[ERR] %0t run took too long", $time);
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk_n(input int a, input int e);
    check_count++;
    if (a != e)
    begin
      n_errors++;
      $display("[ERR] %0t count %0d expected %0d", $time, a, e);
    end
  endtask

  task automatic chk_w(input wcf_word_t a, input wcf_word_t e);
    check_count++;
    if (a !== e)
    begin
      n_errors++;
      $display("[ERR] %0t word %h expected %h", $time, a, e);
    end
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic wait_idle(output bit ok);
    ok = 1'b0;
    for (int k = 0; k < 60 && !ok; k++)
    begin
      @(posedge sys_clk);
      ok = (frame_ready_q === 1'b1);
    end
  endtask

  task automatic drain;
    for (int k = 0; k < 200 && got.size() < exp_q.size(); k++)
      @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
    chk_n(got.size(), exp_q.size());
    while (got.size() > 0 && exp_q.size() > 0)
      chk_w(got.pop_front(), exp_q.pop_front());
    got.delete();
    exp_q.delete();
  endtask

  // one frame; expectations follow from the mode and the injected fault
  task automatic run(input wcf_cfg_t c, input logic [2:0] col,
                     input logic otf, input logic [15:0] s,
                     input logic [1:0] flt);
    logic [143:0] raw;
    bit ok;
    bit bad;
    int a0;
    int c0;
    a0 = n_alert;
    c0 = n_cerr;
    bad = c.crc_en && (c.bc4 ? otf : col != 3'h0);
    cfg <= c;
    wait_idle(ok);
    wcf_ctrl_model_inst.send(c, col, otf, {9{s}}, flt, raw);
    wait_idle(ok);
    chk_n(ok, 1);
    if (!bad && !(flt[0] && c.dm_en))
      exp_q.push_back({raw, c.bc4, c.bc4 & col[2], flt[0], flt[1]});
    chk_n(n_alert - a0, flt[0]);
    chk_n(n_cerr - c0, bad);
    if (core_ready)
      drain();
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic sc_x8_bl8;
    run('{WCF_X8, 0, 0, 0, 1}, 3'h0, 1'b0, 16'h5a3c, 2'b00);
    run('{WCF_X8, 0, 1, 0, 1}, 3'h0, 1'b0, 16'h0ff1, 2'b00);
    run('{WCF_X8, 0, 0, 0, 1}, 3'h0, 1'b0, 16'h1234, 2'b10);
  endtask

  task automatic sc_x4_bl8;
    run('{WCF_X4, 0, 0, 0, 1}, 3'h0, 1'b0, 16'hc3a5, 2'b00);
  endtask

  task automatic sc_x16;
    run('{WCF_X16, 0, 0, 1, 1}, 3'h0, 1'b0, 16'h9e17, 2'b00);
    run('{WCF_X16, 0, 0, 0, 1}, 3'h0, 1'b0, 16'h4b2d, 2'b01);
  endtask

  task automatic sc_x4_bc4;
    run('{WCF_X4, 1, 0, 0, 1}, 3'h0, 1'b0, 16'h6d91, 2'b00);
    run('{WCF_X4, 1, 0, 0, 1}, 3'h4, 1'b0, 16'h6d91, 2'b00);
  endtask

  task automatic sc_x8_bc4;
    run('{WCF_X8, 1, 1, 0, 1}, 3'h0, 1'b0, 16'ha70e, 2'b00);
    run('{WCF_X8, 1, 0, 0, 1}, 3'h0, 1'b0, 16'h0000, 2'b00);
    run('{WCF_X8, 1, 0, 1, 1}, 3'h4, 1'b0, 16'h38c6, 2'b00);
    run('{WCF_X8, 1, 0, 0, 1}, 3'h4, 1'b0, 16'h0100, 2'b00);
  endtask

  task automatic sc_drop;
    run('{WCF_X8, 0, 1, 0, 1}, 3'h0, 1'b0, 16'hbeef, 2'b01);
  endtask

  task automatic sc_refuse;
    run('{WCF_X8, 0, 0, 0, 1}, 3'h1, 1'b0, 16'h1111, 2'b00);
    run('{WCF_X8, 1, 0, 0, 1}, 3'h0, 1'b1, 16'h2222, 2'b00);
    run('{WCF_X8, 0, 0, 0, 0}, 3'h5, 1'b0, 16'h3333, 2'b00);
  endtask

  // core stalls until the buffer refuses, then drains in order
  task automatic sc_fill;
    wcf_cfg_t c;
    logic [143:0] raw;
    bit ok;
    int o0;
    c = '{WCF_X8, 0, 0, 0, 1};
    core_ready <= 1'b0;
    cfg <= c;
    for (int k = 0; k < 6; k++)
    begin
      wait_idle(ok);
      if (!ok)
        break;
      wcf_ctrl_model_inst.send(c, 3'h0, 1'b0, {9{k[15:0]}}, 2'b00, raw);
      exp_q.push_back({raw, 4'h0});
    end
    chk_n(ok, 0);
    o0 = n_ovr;
    wcf_ctrl_model_inst.cmd_only();
    repeat (3) @(posedge sys_clk);
    chk_n(n_ovr - o0, 1);
    core_ready <= 1'b1;
    drain();
  endtask

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    cfg = '0;
    core_ready = 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk_n({frame_ready_q, core_valid, alert_oe_n_q} === 3'b101, 1);
    sc_x8_bl8();
    sc_x4_bl8();
    sc_x16();
    sc_x4_bc4();
    sc_x8_bc4();
    sc_drop();
    sc_refuse();
    sc_fill();
    tally_and_finish();
  end

endmodule

`default_nettype wire
